// ### rtl/fes_pkg.sv
// constants, register map and types of the flash erase and error sequencer
// assumes a 100 MHz bus clock and an 8-bit register port
`default_nettype none
package fes_pkg;
    // clock and array geometry
    localparam int CLK_PERIOD_NS     = 10;
    localparam int ARRAY_ADDR_W      = 15;
    localparam int SECTOR_BYTES      = 512;
    localparam int SECTOR_LSB        = $clog2(SECTOR_BYTES);
    localparam int SECTOR_IDX_W      = ARRAY_ADDR_W - SECTOR_LSB;
    localparam int PULSES_PER_SECTOR = 16;
    localparam int PULSE_W           = $clog2(PULSES_PER_SECTOR + 1);
    // register offsets
    localparam logic [2:0] REG_CLKDIV = 3'h0;
    localparam logic [2:0] REG_CFG    = 3'h1;
    localparam logic [2:0] REG_SEC    = 3'h2;
    localparam logic [2:0] REG_PROT   = 3'h3;
    localparam logic [2:0] REG_STAT   = 3'h4;
    localparam logic [2:0] REG_CMD    = 3'h5;
    localparam logic [2:0] REG_PULSE  = 3'h6;
    // field positions
    localparam int STAT_CMD_BUFFER_EMPTY_FLAG_BIT = 7;
    localparam int STAT_CMD_COMPLETE_FLAG_BIT  = 6;
    localparam int STAT_PROTECTION_VIOLATION_FLAG_BIT = 5;
    localparam int STAT_ACCER_BIT = 4;
    localparam int CFG_CBEIE_BIT  = 7;
    localparam int CFG_CCIE_BIT   = 6;
    localparam int PROT_EN_BIT    = 7;
    // reset values
    localparam logic [7:0] CLKDIV_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] PROT_RESET   = 8'h00;
    localparam logic [1:0] SEC_RESET    = 2'h0;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    // command codes
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'h05;
    localparam logic [7:0] CMD_PROGRAM      = 8'h20;
    localparam logic [7:0] CMD_BURST_PROG   = 8'h25;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;
    localparam logic [7:0] CMD_SET_MARGIN   = 8'h75;
    // margin data and levels
    localparam logic [15:0] MDATA_NORMAL = 16'h0000;
    localparam logic [15:0] MDATA_ZERO   = 16'h0005;
    localparam logic [15:0] MDATA_ONE    = 16'h0024;
    localparam logic [1:0]  MARGIN_NORMAL = 2'h0;
    localparam logic [1:0]  MARGIN_ZERO   = 2'h1;
    localparam logic [1:0]  MARGIN_ONE    = 2'h2;
    // algorithm durations
    localparam int ERASE_PULSE_NS = 20000;
    localparam int MASS_ERASE_NS  = 100000;
    localparam int PROGRAM_NS     = 400;
    localparam int VERIFY_NS      = 1000;
    localparam int MARGIN_NS      = 100;
    localparam int ERASE_PULSE_CYCLES = ERASE_PULSE_NS / CLK_PERIOD_NS;
    localparam int MASS_ERASE_CYCLES  = MASS_ERASE_NS / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES     = PROGRAM_NS / CLK_PERIOD_NS;
    localparam int VERIFY_CYCLES      = VERIFY_NS / CLK_PERIOD_NS;
    localparam int MARGIN_CYCLES      = MARGIN_NS / CLK_PERIOD_NS;
    // command write sequence
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fes_seq_type;
endpackage
`default_nettype wire

// ### rtl/fes_sequencer.sv
// flash command sequencer: write sequence checks, erase and margin commands
// assumes mode inputs come from logic on mclk, array macro driven by outputs
//
// Behaviour
// - sector erase is 16 pulses on a 512-byte sector, each completing alone
// - command 0x40 sector erase, 0x41 mass erase, 0x75 set margin
// - sector erase takes latched address, ignores data, completion flag at end
// - mass erase ignores address and data, refused if any protection
// - erase of a protected sector sets protection flag, no start
// - margin only in special mode; data 0x0000, 0x0005, 0x0024 pick level
// - access error on array write before divider, byte, misaligned, other reg
// - access error on second array address or array write after command
// - after command only the launching status write is allowed
// - undefined command is access error unless address is protected
// - non-burst command while buffer empty and busy is access error
// - secured, non-secure or debug origin allows only verify or mass erase
// - writing zero to buffer-empty bit aborts with access error
// - register reads never error; array reads while busy flag invalid data
// - protection flag at command write for protected program, erase, bad code
// - wait mode lets active and buffered commands finish; wake request
// - stop while active aborts, drops high voltage, purges, sets both flags
// - leaving stop sets buffer-empty and never launches a buffered command
// - protection writable in debug; secured debug allows verify, mass only
// - command 0x05 erase verify and 0x20 program are decoded
`default_nettype none
module fes_sequencer #(
    parameter int MASS_CYCLES  = fes_pkg::MASS_ERASE_CYCLES,
    parameter int ERASE_CYCLES = fes_pkg::ERASE_PULSE_CYCLES,
    parameter int PROG_CYCLES  = fes_pkg::PROGRAM_CYCLES,
    parameter int VER_CYCLES   = fes_pkg::VERIFY_CYCLES,
    parameter int MARG_CYCLES  = fes_pkg::MARGIN_CYCLES,
    parameter int CNT_W        = 17
) (
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst,
    // register port
    input  wire logic [2:0]                        regAddr,
    input  wire logic [7:0]                        regWdata,
    input  wire logic                              regWr,
    input  wire logic                              regRd,
    output logic      [7:0]                        regRdata,
    // array access
    input  wire logic                              arrayWr,
    input  wire logic                              arrayRd,
    input  wire logic                              arrayByte,
    input  wire logic [fes_pkg::ARRAY_ADDR_W-1:0]  arrayAddr,
    input  wire logic [15:0]                       arrayWdata,
    output logic                                   arrayRdInvalid,
    // chip modes
    input  wire logic                              waitMode,
    input  wire logic                              stopMode,
    input  wire logic                              bdmMode,
    input  wire logic                              specialMode,
    input  wire logic                              nonSecureFetch,
    input  wire logic [1:0]                        secByteIn,
    output logic                                   wakeReq,
    // array macro control
    output logic                                   hvOn,
    output logic      [7:0]                        opCode,
    output logic      [fes_pkg::ARRAY_ADDR_W-1:0]  opAddr,
    output logic      [15:0]                       opData,
    output logic      [1:0]                        marginLevel
);
    localparam int AW = fes_pkg::ARRAY_ADDR_W;

    function automatic logic isValidCmd(input logic [7:0] c);
        return c == fes_pkg::CMD_ERASE_VERIFY || c == fes_pkg::CMD_PROGRAM
            || c == fes_pkg::CMD_BURST_PROG || c == fes_pkg::CMD_SECTOR_ERASE
            || c == fes_pkg::CMD_MASS_ERASE || c == fes_pkg::CMD_SET_MARGIN;
    endfunction

    // sectors at or above the bound are protected while enabled
    function automatic logic isProtected(input logic [7:0] p,
                                         input logic [AW-1:0] a);
        return p[fes_pkg::PROT_EN_BIT]
            && a[AW-1:fes_pkg::SECTOR_LSB]
               >= p[fes_pkg::SECTOR_IDX_W-1:0];
    endfunction

    function automatic logic [CNT_W-1:0] opCycles(input logic [7:0] c);
        case (c)
            fes_pkg::CMD_SECTOR_ERASE: return CNT_W'(ERASE_CYCLES);
            fes_pkg::CMD_MASS_ERASE:   return CNT_W'(MASS_CYCLES);
            fes_pkg::CMD_ERASE_VERIFY: return CNT_W'(VER_CYCLES);
            fes_pkg::CMD_SET_MARGIN:   return CNT_W'(MARG_CYCLES);
            default:                   return CNT_W'(PROG_CYCLES);
        endcase
    endfunction

    fes_pkg::fes_seq_type seqState;
    fes_pkg::fes_seq_type next_seqState;
    logic [7:0]                  clkDiv;
    logic                        divLoaded;
    logic [7:0]                  cfgReg;
    logic [7:0]                  protReg;
    logic [1:0]                  secState;
    logic                        secCaptured;
    logic                        cmd_buffer_empty_flag;
    logic                        cmd_complete_flag;
    logic                        pvErr;
    logic                        access_error_flag;
    logic                        busy;
    logic                        pendValid;
    logic [CNT_W-1:0]            opCnt;
    logic [AW-1:0]               seqAddr;
    logic [15:0]                 seqData;
    logic [7:0]                  seqCmd;
    logic [fes_pkg::SECTOR_IDX_W-1:0] pulseSector;
    logic [fes_pkg::PULSE_W-1:0] pulseCount;

    // decode of the register port
    wire regWrStat  = regWr && regAddr == fes_pkg::REG_STAT;
    wire regWrCmd   = regWr && regAddr == fes_pkg::REG_CMD;
    wire inIdle     = seqState == fes_pkg::SEQ_IDLE;
    wire inAddr     = seqState == fes_pkg::SEQ_ADDR;
    wire inCmd      = seqState == fes_pkg::SEQ_CMD;
    wire secure     = secState != fes_pkg::SEC_UNSECURED;
    wire protEn     = protReg[fes_pkg::PROT_EN_BIT];
    wire launchBit  = regWdata[fes_pkg::STAT_CMD_BUFFER_EMPTY_FLAG_BIT];

    // new sequences wait for clear flags and a free buffer
    wire seqStartTry = inIdle && arrayWr && cmd_buffer_empty_flag && !access_error_flag && !pvErr
                       && !stopMode;
    wire badArrWr    = !divLoaded || arrayByte || arrayAddr[0];
    wire seqStart    = seqStartTry && !badArrWr;
    wire accIdle     = seqStartTry && badArrWr;
    wire accAddr     = inAddr && (arrayWr || (regWr && !regWrCmd));

    // command evaluation, protection outranks the access checks
    wire       cmdTry     = inAddr && regWrCmd && !arrayWr;
    wire [7:0] cmdCode    = regWdata;
    wire       protAddr   = isProtected(protReg, seqAddr);
    wire       cmdInvalid = !isValidCmd(cmdCode)
                            || (cmdCode == fes_pkg::CMD_SET_MARGIN
                                && !specialMode);
    wire pvCond = (protAddr && (cmdCode == fes_pkg::CMD_PROGRAM
                   || cmdCode == fes_pkg::CMD_BURST_PROG
                   || cmdCode == fes_pkg::CMD_SECTOR_ERASE
                   || !isValidCmd(cmdCode)))
                  || (cmdCode == fes_pkg::CMD_MASS_ERASE && protEn);
    wire secBlock = secure && (nonSecureFetch || bdmMode)
                    && cmdCode != fes_pkg::CMD_ERASE_VERIFY
                    && cmdCode != fes_pkg::CMD_MASS_ERASE;
    // only burst may queue behind a running command
    wire busyBlock = busy && cmd_buffer_empty_flag && cmdCode != fes_pkg::CMD_BURST_PROG;
    wire cmdPv     = cmdTry && pvCond;
    wire cmdAcc    = cmdTry && !pvCond
                     && (cmdInvalid || secBlock || busyBlock);
    wire cmdOk     = cmdTry && !pvCond && !cmdAcc;

    // only a launching status write after the command
    wire accCmd = inCmd && (arrayWr || (regWr && !(regWrStat && launchBit)));
    wire launch = inCmd && !arrayWr && regWrStat && launchBit && !stopMode;

    wire stopAbort   = stopMode && busy;
    wire opDone      = busy && opCnt == CNT_W'(1) && !stopMode;
    wire startNew    = launch && (!busy || opDone);
    wire queueLaunch = launch && busy && !opDone;
    wire takePending = opDone && pendValid;
    wire startOp     = startNew || takePending;
    wire accSet = stopAbort
                  || (!stopMode && (accIdle || accAddr || cmdAcc || accCmd));
    wire pvSet  = !stopMode && cmdPv;

    always_comb begin
        next_seqState = seqState;
        unique case (seqState)
            fes_pkg::SEQ_IDLE: begin
                // the array write opens a sequence
                if (seqStart)
                    next_seqState = fes_pkg::SEQ_ADDR;
            end
            fes_pkg::SEQ_ADDR: begin
                if (cmdOk)
                    next_seqState = fes_pkg::SEQ_CMD;
                else if (accAddr || cmdPv || cmdAcc)
                    next_seqState = fes_pkg::SEQ_IDLE;
            end
            fes_pkg::SEQ_CMD: begin
                if (accCmd || launch)
                    next_seqState = fes_pkg::SEQ_IDLE;
            end
        endcase
        if (stopMode)
            next_seqState = fes_pkg::SEQ_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (rst)
            seqState <= fes_pkg::SEQ_IDLE;
        else
            seqState <= next_seqState;
    end

    // address and data latched, meaning chosen by the command
    always_ff @(posedge mclk) begin
        if (rst) begin
            seqAddr <= '0;
            seqData <= 16'h0000;
            seqCmd  <= 8'h00;
        end else begin
            if (seqStart) begin
                seqAddr <= arrayAddr;
                seqData <= arrayWdata;
            end
            if (cmdOk)
                seqCmd <= cmdCode;
        end
    end

    // buffer empty again on stop; a queued launch is purged
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_buffer_empty_flag     <= 1'b1;
            pendValid <= 1'b0;
        end else if (stopMode) begin
            cmd_buffer_empty_flag     <= 1'b1;
            pendValid <= 1'b0;
        end else if (queueLaunch) begin
            cmd_buffer_empty_flag     <= 1'b0;
            pendValid <= 1'b1;
        end else if (takePending) begin
            cmd_buffer_empty_flag     <= 1'b1;
            pendValid <= 1'b0;
        end
    end

    // wait mode does not stall the engine
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy  <= 1'b0;
            cmd_complete_flag  <= 1'b1;
            opCnt <= '0;
        end else if (stopMode) begin
            busy  <= 1'b0;
            cmd_complete_flag  <= cmd_complete_flag || busy;
            opCnt <= '0;
        end else if (startOp) begin
            busy  <= 1'b1;
            cmd_complete_flag  <= 1'b0;
            opCnt <= opCycles(seqCmd);
        end else if (busy) begin
            busy  <= !opDone;
            cmd_complete_flag  <= opDone;
            opCnt <= opCnt - CNT_W'(1);
        end
    end

    // high voltage follows the engine except for verify and margin, dropped at once by stop
    always_ff @(posedge mclk) begin
        if (rst) begin
            hvOn   <= 1'b0;
            opCode <= 8'h00;
            opAddr <= '0;
            opData <= 16'h0000;
        end else if (stopMode || (opDone && !startOp)) begin
            hvOn   <= 1'b0;
        end else if (startOp) begin
            hvOn   <= seqCmd != fes_pkg::CMD_ERASE_VERIFY
                      && seqCmd != fes_pkg::CMD_SET_MARGIN;
            opCode <= seqCmd;
            opAddr <= seqAddr;
            opData <= seqData;
        end
    end

    // one pulse counted per completed sector erase
    wire [fes_pkg::SECTOR_IDX_W-1:0] opSector =
        opAddr[AW-1:fes_pkg::SECTOR_LSB];
    wire pulseDone = opDone && opCode == fes_pkg::CMD_SECTOR_ERASE;
    wire pulseSat  = pulseCount == fes_pkg::PULSE_W'(fes_pkg::PULSES_PER_SECTOR);

    always_ff @(posedge mclk) begin
        if (rst) begin
            pulseSector <= '0;
            pulseCount  <= '0;
        end else if (pulseDone) begin
            pulseSector <= opSector;
            if (opSector != pulseSector || pulseCount == '0)
                pulseCount <= fes_pkg::PULSE_W'(1);
            else if (!pulseSat)
                pulseCount <= pulseCount + fes_pkg::PULSE_W'(1);
        end
    end

    // level applies to later reads; unknown data leaves it unchanged
    always_ff @(posedge mclk) begin
        if (rst)
            marginLevel <= fes_pkg::MARGIN_NORMAL;
        else if (opDone && opCode == fes_pkg::CMD_SET_MARGIN) begin
            if (opData == fes_pkg::MDATA_NORMAL)
                marginLevel <= fes_pkg::MARGIN_NORMAL;
            else if (opData == fes_pkg::MDATA_ZERO)
                marginLevel <= fes_pkg::MARGIN_ZERO;
            else if (opData == fes_pkg::MDATA_ONE)
                marginLevel <= fes_pkg::MARGIN_ONE;
        end
    end

    // set wins over the write-one clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            access_error_flag <= 1'b0;
            pvErr  <= 1'b0;
        end else begin
            access_error_flag <= accSet || (access_error_flag
                      && !(regWrStat && regWdata[fes_pkg::STAT_ACCER_BIT]));
            pvErr  <= pvSet || (pvErr
                      && !(regWrStat && regWdata[fes_pkg::STAT_PROTECTION_VIOLATION_FLAG_BIT]));
        end
    end

    // security byte caught on the first edge after reset release
    always_ff @(posedge mclk) begin
        if (rst) begin
            secState    <= fes_pkg::SEC_RESET;
            secCaptured <= 1'b0;
        end else if (!secCaptured) begin
            secState    <= secByteIn;
            secCaptured <= 1'b1;
        end
    end

    // protection writable from debug or while unsecured
    always_ff @(posedge mclk) begin
        if (rst) begin
            clkDiv    <= fes_pkg::CLKDIV_RESET;
            divLoaded <= 1'b0;
            cfgReg    <= fes_pkg::CFG_RESET;
            protReg   <= fes_pkg::PROT_RESET;
        end else if (regWr) begin
            if (regAddr == fes_pkg::REG_CLKDIV) begin
                clkDiv    <= regWdata;
                divLoaded <= 1'b1;
            end
            if (regAddr == fes_pkg::REG_CFG)
                cfgReg <= regWdata;
            if (regAddr == fes_pkg::REG_PROT && (bdmMode || !secure))
                protReg <= regWdata;
        end
    end

    wire [7:0] statVal = {cmd_buffer_empty_flag, cmd_complete_flag, pvErr, access_error_flag, 4'h0};
    wire [7:0] rdMux =
        (regAddr == fes_pkg::REG_CLKDIV) ? clkDiv :
        (regAddr == fes_pkg::REG_CFG)    ? cfgReg :
        (regAddr == fes_pkg::REG_SEC)    ? {6'h00, secState} :
        (regAddr == fes_pkg::REG_PROT)   ? protReg :
        (regAddr == fes_pkg::REG_STAT)   ? statVal :
        (regAddr == fes_pkg::REG_CMD)    ? seqCmd :
        (regAddr == fes_pkg::REG_PULSE)  ? {3'h0, pulseCount} : 8'h00;

    always_ff @(posedge mclk) begin
        if (rst)
            regRdata <= 8'h00;
        else
            regRdata <= regRd ? rdMux : 8'h00;
    end

    // array data is not valid while an algorithm runs
    assign arrayRdInvalid = arrayRd && !cmd_complete_flag;
    // wake from wait on enabled flags
    assign wakeReq = waitMode
        && ((cfgReg[fes_pkg::CFG_CBEIE_BIT] && cmd_buffer_empty_flag)
            || (cfgReg[fes_pkg::CFG_CCIE_BIT] && cmd_complete_flag));

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_stop_flags: assert property (
        stopMode && busy |=> cmd_complete_flag && access_error_flag && !hvOn && !busy && !pendValid)
        else $error("stop abort left command state behind");
    a_stop_exit: assert property (
        $fell(stopMode) |-> cmd_buffer_empty_flag && !pendValid && !busy)
        else $error("buffered command survived stop");
    a_prot_sector: assert property (
        cmdTry && !stopMode && cmdCode == fes_pkg::CMD_SECTOR_ERASE
        && protAddr |=> pvErr && !access_error_flag && inIdle)
        else $error("protected sector erase not refused");
    a_mass_prot: assert property (
        cmdTry && !stopMode && cmdCode == fes_pkg::CMD_MASS_ERASE && protEn
        |=> pvErr && inIdle ##1 !(busy && opCode == fes_pkg::CMD_MASS_ERASE
        && !$past(busy, 1)))
        else $error("mass erase launched under protection");
    a_second_addr: assert property (
        inAddr && arrayWr && !stopMode |=> access_error_flag && inIdle)
        else $error("second array address not flagged");
    a_zero_launch: assert property (
        inCmd && regWrStat && !launchBit && !stopMode
        |=> access_error_flag && inIdle && $stable(busy))
        else $error("zero launch bit did not abort");
    a_bad_cmd: assert property (
        cmdTry && !stopMode && !isValidCmd(cmdCode) && !protAddr
        |=> access_error_flag && !pvErr)
        else $error("undefined command not flagged");
    a_busy_cmd: assert property (
        cmdTry && !stopMode && busy && !pvCond
        && cmdCode != fes_pkg::CMD_BURST_PROG |=> access_error_flag)
        else $error("command accepted while busy");
    a_early_write: assert property (
        seqStartTry && !divLoaded |=> access_error_flag && inIdle)
        else $error("array write before divider accepted");
    a_pulse_step: assert property (
        pulseDone && opSector == pulseSector && pulseCount != '0 && !pulseSat
        |=> pulseCount == $past(pulseCount) + fes_pkg::PULSE_W'(1))
        else $error("erase pulse not counted");
    a_margin_zero: assert property (
        opDone && opCode == fes_pkg::CMD_SET_MARGIN
        && opData == fes_pkg::MDATA_ZERO |=> marginLevel == fes_pkg::MARGIN_ZERO
        ##1 cmd_complete_flag)
        else $error("margin level not applied");
endmodule
`default_nettype wire

// ### test/test_fes_sequencer.sv
// bench: command sequences, access and protection errors, erase, margin
// assumes the sequencer alone, short algorithm durations
`default_nettype none
module test_fes_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst, regWr, regRd, arrayWr, arrayRd, arrayByte;
    logic        waitMode, stopMode, bdmMode, specialMode, nonSecureFetch;
    logic        arrayRdInvalid, wakeReq, hvOn;
    logic [1:0]  secByteIn, marginLevel;
    logic [2:0]  regAddr;
    logic [5:0]  sec;
    logic [7:0]  regWdata, regRdata, opCode, v, seed;
    logic [14:0] arrayAddr, opAddr;
    logic [15:0] arrayWdata, opData;
    int          fails, nCompared;
    fes_sequencer #(.MASS_CYCLES(12), .ERASE_CYCLES(8), .PROG_CYCLES(4),
        .VER_CYCLES(4), .MARG_CYCLES(4)) i_dut (.mclk, .rst, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .arrayWr, .arrayRd, .arrayByte,
        .arrayAddr, .arrayWdata, .arrayRdInvalid, .waitMode, .stopMode,
        .bdmMode, .specialMode, .nonSecureFetch, .secByteIn, .wakeReq, .hvOn,
        .opCode, .opAddr, .opData, .marginLevel);
    function automatic logic [14:0] rnd(input logic [5:0] s);
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return {s, seed, 1'b0};
    endfunction
    function automatic logic [7:0] st(input logic p, input logic a);
        return {2'b11, p, a, 4'h0};
    endfunction
    task automatic stop_test();
        if (fails == 0 && nCompared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        nCompared++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", n, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic aw(input logic [14:0] a, input logic b,
                      input logic [15:0] d);
        @(posedge mclk);
        arrayAddr <= a;
        arrayByte <= b;
        arrayWdata <= d;
        arrayWr <= 1'b1;
        @(posedge mclk);
        arrayWr <= 1'b0;
        arrayByte <= 1'b0;
    endtask
    task automatic seq(input logic [14:0] a, input logic [7:0] c,
                       input logic [7:0] s, input logic [15:0] d);
        aw(a, 1'b0, d);
        wr(fes_pkg::REG_CMD, c);
        wr(fes_pkg::REG_STAT, s);
    endtask
    // launch, read while busy, then poll for completion
    task automatic launch(input logic [14:0] a, input logic [7:0] c,
                          input logic [15:0] d);
        seq(a, c, 8'h80, d);
        arrayRd <= 1'b1;
        #1 chk("opCode", c, opCode);
        if (c == 8'h40) chk("op sector", a[14:9], opAddr[14:9]);
        if (c == 8'h20) chk("op data", d, opData);
        chk("hv on", c != 8'h05 && c != 8'h75, hvOn);
        chk("read invalid", 1, arrayRdInvalid);
        @(posedge mclk);
        arrayRd <= 1'b0;
        v = '0;
        for (int n = 0; n < 100 && v[6] !== 1'b1; n++) rd(fes_pkg::REG_STAT);
        chk("stat done", st(0, 0), v);
    endtask
    // illegal steps: case 9 is an aligned write before the divider
    task automatic bad(input int k);
        logic [14:0] a;
        a = rnd(6'h05);
        aw(a | 15'(k == 0), k == 1, 16'h0);
        case (k)
            2: aw(a, 1'b0, 16'h0);
            3: wr(fes_pkg::REG_CFG, 8'h00);
            4: wr(fes_pkg::REG_CMD, 8'h33);
            5: wr(fes_pkg::REG_CMD, fes_pkg::CMD_SET_MARGIN);
            default: wr(fes_pkg::REG_CMD, fes_pkg::CMD_SECTOR_ERASE);
        endcase
        case (k)
            5: wr(fes_pkg::REG_STAT, 8'h80);
            6: wr(fes_pkg::REG_CFG, 8'h00);
            7: aw(a, 1'b0, 16'h0);
            8: wr(fes_pkg::REG_STAT, 8'h00);
            default: ;
        endcase
        rd(fes_pkg::REG_STAT);
        chk("stat access", st(0, 1), v);
        wr(fes_pkg::REG_STAT, 8'h10);
    endtask
    task automatic prot(input logic [14:0] a, input logic [7:0] c);
        seq(a, c, 8'h80, 16'h0);
        rd(fes_pkg::REG_STAT);
        chk("stat protect", st(1, 0), v);
        wr(fes_pkg::REG_STAT, 8'h20);
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        stop_test();
    end
    initial begin
        {regWr, regRd, arrayWr, arrayRd, arrayByte, waitMode} = '0;
        {stopMode, bdmMode, specialMode, nonSecureFetch} = '0;
        {regAddr, regWdata, arrayAddr, arrayWdata} = '0;
        {rst, seed, secByteIn} = {1'b1, 8'h5E, fes_pkg::SEC_UNSECURED};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(fes_pkg::REG_STAT);
        chk("stat reset", 8'hC0, v);
        bad(9);
        wr(fes_pkg::REG_CLKDIV, 8'h13);
        for (int k = 0; k < 9; k++) bad(k);
        bdmMode <= 1'b1;
        wr(fes_pkg::REG_PROT, 8'hA0);
        bdmMode <= 1'b0;
        prot(rnd(6'h21), fes_pkg::CMD_SECTOR_ERASE);
        prot(rnd(6'h01), fes_pkg::CMD_MASS_ERASE);
        prot(rnd(6'h3F), 8'h33);
        prot(rnd(6'h20), fes_pkg::CMD_PROGRAM);
        bdmMode <= 1'b1;
        wr(fes_pkg::REG_PROT, 8'h00);
        bdmMode <= 1'b0;
        launch(rnd(6'h3E), fes_pkg::CMD_MASS_ERASE, {seed, seed});
        launch(rnd(6'h09), fes_pkg::CMD_ERASE_VERIFY, 16'h0);
        launch(rnd(6'h0A), fes_pkg::CMD_PROGRAM, {seed, 8'h3C});
        sec = seed[5:0] & 6'h1F;
        for (int p = 1; p <= 17; p++) begin
            launch(rnd(p == 17 ? sec ^ 6'h01 : sec),
                   fes_pkg::CMD_SECTOR_ERASE, {seed, seed});
            rd(fes_pkg::REG_PULSE);
            chk("pulse count", p == 17 ? 1 : p, v[4:0]);
        end
        specialMode <= 1'b1;
        launch(rnd(6'h02), fes_pkg::CMD_SET_MARGIN, fes_pkg::MDATA_ZERO);
        chk("margin zero", fes_pkg::MARGIN_ZERO, marginLevel);
        launch(rnd(6'h02), fes_pkg::CMD_SET_MARGIN, fes_pkg::MDATA_ONE);
        chk("margin one", fes_pkg::MARGIN_ONE, marginLevel);
        launch(rnd(6'h02), fes_pkg::CMD_SET_MARGIN, fes_pkg::MDATA_NORMAL);
        chk("margin normal", fes_pkg::MARGIN_NORMAL, marginLevel);
        seq(rnd(6'h03), fes_pkg::CMD_SECTOR_ERASE, 8'h80, 16'h0);
        stopMode <= 1'b1;
        @(posedge mclk);
        #1 chk("hv off", 0, hvOn);
        stopMode <= 1'b0;
        rd(fes_pkg::REG_STAT);
        chk("stat stop", st(0, 1), v);
        wr(fes_pkg::REG_STAT, 8'h10);
        rd(fes_pkg::REG_STAT);
        chk("stat cleared", 8'hC0, v);
        wr(fes_pkg::REG_CFG, 8'h40);
        waitMode <= 1'b1;
        #1 chk("wake", 1, wakeReq);
        stop_test();
    end
endmodule
`default_nettype wire
